//--- lcr_consts.vh
`ifndef LCR_CONSTS_VH
`define LCR_CONSTS_VH

// Register indices; byte address is four times the index
`define LCR_IDX_FIRST_CTRL 10'h051
`define LCR_IDX_SECOND_VOLT 10'h054
`define LCR_IDX_SECOND_CTRL 10'h055
`define LCR_IDX_THIRD_VOLT 10'h060
`define LCR_IDX_THIRD_CTRL 10'h061
`define LCR_IDX_FOURTH_VOLT 10'h064
`define LCR_IDX_FOURTH_CTRL 10'h065
`define LCR_IDX_IRQ_STATUS 10'h080
`define LCR_IDX_IRQ_CLEAR 10'h081
`define LCR_IDX_IRQ_ENABLE 10'h082

// Control and voltage byte field positions
`define LCR_CTRL_ENABLE 7
`define LCR_CTRL_DISCHARGE 6
`define LCR_CTRL_LOW_IQ 5
`define LCR_CTRL_DELAY_HI 4
`define LCR_CTRL_DELAY_LO 2
`define LCR_CTRL_FAULT_ALLOW 1
`define LCR_CTRL_POWER_OK 0
`define LCR_VOLT_HI 5
`define LCR_VOLT_LO 0

// Reset values
`define LCR_RST_VOLT 6'h00
`define LCR_RST_CTRL 7'h00
`define LCR_RST_IRQ 3'h0

// AXI responses
`define LCR_RESP_OKAY 2'h0
`define LCR_RESP_SLVERR 2'h2

`endif

//--- lcr_ldo_regs.v
`timescale 1ns/1ps
`include "lcr_consts.vh"

module lcr_ldo_regs #(
  parameter ADDR_W = 12,
  parameter CHANS = 3
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  // Regulator status from the analog side
  input wire firstPowerOk,
  input wire [CHANS-1:0] powerOk,
  input wire [CHANS-1:0] regFault,
  // Regulator controls, channel 0 is the second LDO
  output wire [CHANS-1:0] ldoEnable,
  output wire [CHANS-1:0] dischargeOn,
  output wire [CHANS-1:0] lowQuiescentMode,
  output wire [3*CHANS-1:0] turnOnDelay,
  output wire [6*CHANS-1:0] voltageCode,
  // Interrupt
  output wire irq
);

  // ****************************************
  // Bus handshake state
  // ****************************************
  reg awHeld_q;
  reg wHeld_q;
  reg bValid_q;
  reg [1:0] bResp_q;
  reg [9:0] wIdx_q;
  reg [7:0] wByte_q;
  reg wLane_q;
  reg rValid_q;
  reg [31:0] rData_q;
  reg [1:0] rResp_q;

  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire arTake = s_axi_arvalid && s_axi_arready;
  // Write commits once both halves are latched
  wire doWrite = awHeld_q && wHeld_q && !bValid_q;
  wire wrOk = doWrite && wLane_q;

  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready = !wHeld_q && !bValid_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

  // ****************************************
  // Register map helpers
  // ****************************************
  // Channel 0 is the second regulator
  function [9:0] voltIndex;
    input integer chan;
    begin
      case (chan)
        0: voltIndex = `LCR_IDX_SECOND_VOLT;
        1: voltIndex = `LCR_IDX_THIRD_VOLT;
        default: voltIndex = `LCR_IDX_FOURTH_VOLT;
      endcase
    end
  endfunction

  function [9:0] ctrlIndex;
    input integer chan;
    begin
      case (chan)
        0: ctrlIndex = `LCR_IDX_SECOND_CTRL;
        1: ctrlIndex = `LCR_IDX_THIRD_CTRL;
        default: ctrlIndex = `LCR_IDX_FOURTH_CTRL;
      endcase
    end
  endfunction

  // Unmapped indices answer with an error response
  function isMapped;
    input [9:0] idx;
    begin
      case (idx)
        `LCR_IDX_FIRST_CTRL, `LCR_IDX_SECOND_VOLT, `LCR_IDX_SECOND_CTRL,
        `LCR_IDX_THIRD_VOLT, `LCR_IDX_THIRD_CTRL, `LCR_IDX_FOURTH_VOLT,
        `LCR_IDX_FOURTH_CTRL, `LCR_IDX_IRQ_STATUS, `LCR_IDX_IRQ_CLEAR,
        `LCR_IDX_IRQ_ENABLE: isMapped = 1'b1;
        default: isMapped = 1'b0;
      endcase
    end
  endfunction

  // ****************************************
  // Channel registers
  // ****************************************
  reg [2:0] irqStatus_q;
  reg [2:0] irqEnable_q;
  wire [6*CHANS-1:0] voltFlat;
  wire [7*CHANS-1:0] ctrlFlat;
  wire [CHANS-1:0] faultEvent;

  genvar i;
  generate
    for (i = 0; i < CHANS; i = i + 1) begin : gChan
      localparam [9:0] VIDX = voltIndex(i);
      localparam [9:0] CIDX = ctrlIndex(i);
      reg [5:0] volt_q;
      // Bits 7:1 of the control byte; bit 0 is live status
      reg [6:0] ctrl_q;
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          volt_q <= `LCR_RST_VOLT;
        end else if (wrOk && wIdx_q == VIDX) begin
          volt_q <= wByte_q[`LCR_VOLT_HI:`LCR_VOLT_LO];
        end
      end

      // Power-OK bit is never stored, so writes cannot touch it
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          ctrl_q <= `LCR_RST_CTRL;
        end else if (wrOk && wIdx_q == CIDX) begin
          ctrl_q <= wByte_q[7:1];
        end
      end

      assign voltFlat[6*i+5:6*i] = volt_q;
      assign ctrlFlat[7*i+6:7*i] = ctrl_q;
      assign voltageCode[6*i+5:6*i] = volt_q;
      assign ldoEnable[i] = ctrl_q[`LCR_CTRL_ENABLE-1];
      // Discharge only while the regulator is shut down
      assign dischargeOn[i] = ctrl_q[`LCR_CTRL_DISCHARGE-1] &&
        !ctrl_q[`LCR_CTRL_ENABLE-1];
      assign lowQuiescentMode[i] = ctrl_q[`LCR_CTRL_LOW_IQ-1];
      assign turnOnDelay[3*i+2:3*i] =
        ctrl_q[`LCR_CTRL_DELAY_HI-1:`LCR_CTRL_DELAY_LO-1];
      assign faultEvent[i] = regFault[i] &&
        ctrl_q[`LCR_CTRL_FAULT_ALLOW-1];
    end
  endgenerate

  // ****************************************
  // Interrupt status
  // ****************************************
  wire wrIrqClear = wrOk && (wIdx_q == `LCR_IDX_IRQ_CLEAR);
  wire wrIrqEnable = wrOk && (wIdx_q == `LCR_IDX_IRQ_ENABLE);

  wire [2:0] clrBits = wrIrqClear ? wByte_q[2:0] : 3'h0;
  // A fault in the clearing cycle stays latched
  wire [2:0] irqStatus_d = (irqStatus_q & ~clrBits) | faultEvent;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStatus_q <= `LCR_RST_IRQ;
      irqEnable_q <= `LCR_RST_IRQ;
    end else begin
      irqStatus_q <= irqStatus_d;
      if (wrIrqEnable) begin
        irqEnable_q <= wByte_q[2:0];
      end
    end
  end

  wire [2:0] irqPending = irqStatus_q & irqEnable_q;

  assign irq = |irqPending;

  // ****************************************
  // Write path
  // ****************************************
  wire wMapped = isMapped(wIdx_q);

  // Address half; a held half refuses the next until its write response is taken
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_q <= 1'b0;
      wIdx_q <= 10'h000;
    end else if (awTake) begin
      awHeld_q <= 1'b1;
      wIdx_q <= s_axi_awaddr[11:2];
    end else if (doWrite) begin
      awHeld_q <= 1'b0;
    end
  end

  // Data half
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wHeld_q <= 1'b0;
      wByte_q <= 8'h00;
      wLane_q <= 1'b0;
    end else if (wTake) begin
      wHeld_q <= 1'b1;
      wByte_q <= s_axi_wdata[7:0];
      // Only byte lane 0 carries register data
      wLane_q <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld_q <= 1'b0;
    end
  end

  // Response
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bValid_q <= 1'b0;
      bResp_q <= `LCR_RESP_OKAY;
    end else if (doWrite) begin
      bValid_q <= 1'b1;
      bResp_q <= wMapped ? `LCR_RESP_OKAY : `LCR_RESP_SLVERR;
    end else if (bValid_q && s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Read views; reserved bits read as zero
  wire [7:0] firstCtrlRd = {7'h00, firstPowerOk};
  wire [7:0] secondVoltRd = {2'h0, voltFlat[5:0]};
  wire [7:0] secondCtrlRd = {ctrlFlat[6:0], powerOk[0]};
  wire [7:0] thirdVoltRd = {2'h0, voltFlat[11:6]};
  wire [7:0] thirdCtrlRd = {ctrlFlat[13:7], powerOk[1]};
  wire [7:0] fourthVoltRd = {2'h0, voltFlat[17:12]};
  wire [7:0] fourthCtrlRd = {ctrlFlat[20:14], powerOk[2]};
  wire [7:0] statusRd = {5'h00, irqStatus_q};
  wire [7:0] enableRd = {5'h00, irqEnable_q};

  reg [7:0] rByte;
  reg rMapped;
  always @* begin
    rByte = 8'h00;
    rMapped = 1'b1;
    case (s_axi_araddr[11:2])
      `LCR_IDX_FIRST_CTRL: rByte = firstCtrlRd;
      `LCR_IDX_SECOND_VOLT: rByte = secondVoltRd;
      `LCR_IDX_SECOND_CTRL: rByte = secondCtrlRd;
      `LCR_IDX_THIRD_VOLT: rByte = thirdVoltRd;
      `LCR_IDX_THIRD_CTRL: rByte = thirdCtrlRd;
      `LCR_IDX_FOURTH_VOLT: rByte = fourthVoltRd;
      `LCR_IDX_FOURTH_CTRL: rByte = fourthCtrlRd;
      `LCR_IDX_IRQ_STATUS: rByte = statusRd;
      `LCR_IDX_IRQ_CLEAR: rByte = 8'h00;
      `LCR_IDX_IRQ_ENABLE: rByte = enableRd;
      default: rMapped = 1'b0;
    endcase
  end

  // Read valid; one read outstanding at a time
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rValid_q <= 1'b0;
    end else if (arTake) begin
      rValid_q <= 1'b1;
    end else if (rValid_q && s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  // Data is frozen at the address edge and stands until taken
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rData_q <= 32'h00000000;
      rResp_q <= `LCR_RESP_OKAY;
    end else if (arTake) begin
      rData_q <= {24'h000000, rByte};
      rResp_q <= rMapped ? `LCR_RESP_OKAY : `LCR_RESP_SLVERR;
    end
  end

endmodule // lcr_ldo_regs

//--- lcr_ldo_regs_assertions.sv
`timescale 1ns/1ps
// ********
// Register bank checks
// ********
module lcr_ldo_checker #(
  parameter ADDR_W = 12,
  parameter CHANS = 3
) (
  // Clock, reset, bus
  input wire ref_clk,
  input wire sys_rst,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_bvalid,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  // Regulator side
  input wire [CHANS-1:0] powerOk,
  input wire [CHANS-1:0] regFault,
  input wire [CHANS-1:0] ldoEnable,
  input wire [CHANS-1:0] dischargeOn,
  input wire [CHANS-1:0] lowQuiescentMode,
  input wire [3*CHANS-1:0] turnOnDelay,
  input wire [6*CHANS-1:0] voltageCode,
  input wire irq
);
  logic [9:0] rdIdx_q;
  // Index of the read being answered
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) rdIdx_q <= 10'h000;
    else if (s_axi_arvalid && s_axi_arready) rdIdx_q <= s_axi_araddr[11:2];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_volt_write: assert property (
    !$stable(voltageCode) |-> $rose(s_axi_bvalid)) else $error("volt moved");
  chk_enable_write: assert property (
    !$stable(ldoEnable) |-> $rose(s_axi_bvalid)) else $error("enable moved");
  chk_discharge_off: assert property (
    ~|(dischargeOn & ldoEnable)) else $error("discharge while on");
  chk_low_quiescent_mode_write: assert property (
    !$stable(lowQuiescentMode) |-> $rose(s_axi_bvalid)) else $error("low_quiescent_mode");
  chk_delay_write: assert property (
    !$stable(turnOnDelay) |-> $rose(s_axi_bvalid)) else $error("delay moved");
  chk_irq_cause: assert property (
    $rose(irq) |-> (|$past(regFault)) || $rose(s_axi_bvalid))
    else $error("irq without cause");
  chk_power_ok: assert property (
    $rose(s_axi_rvalid) && rdIdx_q == 10'h055 |->
    s_axi_rdata[0] == $past(powerOk[0])) else $error("power ok bit");
  chk_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper");
endmodule // lcr_ldo_checker
bind lcr_ldo_regs lcr_ldo_checker #(.ADDR_W(ADDR_W), .CHANS(CHANS)) chkInst (
  .ref_clk, .sys_rst, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata, .powerOk, .regFault,
  .ldoEnable, .dischargeOn, .lowQuiescentMode, .turnOnDelay,
  .voltageCode, .irq);

//--- tb.sv
`timescale 1ns/1ps
module tb;
  logic ref_clk = '0, sys_rst = 1'h1, firstPowerOk = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, powerOk = '0, regFault = '0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] ldoEnable, dischargeOn, lowQuiescentMode;
  wire [8:0] turnOnDelay;
  wire [17:0] voltageCode;
  int bad_count = 0, samples_checked = 0;
  logic [11:0] va [3] = '{12'h150, 12'h180, 12'h190};
  lcr_ldo_regs lcr_ldo_regs_inst (.ref_clk, .sys_rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .firstPowerOk, .powerOk, .regFault, .ldoEnable, .dischargeOn,
    .lowQuiescentMode, .turnOnDelay, .voltageCode, .irq);
  always #5 ref_clk = ~ref_clk;
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("checked=%0d bad=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
    input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    cmp(s_axi_rdata, e);
    cmp(s_axi_rresp, r);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'h0;
    @(posedge ref_clk);
    rd(12'h154, 32'h0, 2'h0);
    for (int i = 0; i < 3; i++) begin
      wr(va[i], 8'hFF);
      rd(va[i], 32'h3F, 2'h0);
      wr(va[i] + 12'h004, 8'hFF);
      rd(va[i] + 12'h004, 32'hFE, 2'h0);
    end
    cmp(voltageCode, 32'h3FFFF);
    cmp({ldoEnable, lowQuiescentMode, turnOnDelay}, 32'h7FFF);
    wr(12'h180, 8'h95);
    rd(12'h180, 32'h15, 2'h0);
    cmp(voltageCode[11:6], 32'h15);
    s_axi_wstrb <= 4'hE;
    wr(12'h190, 8'h00);
    s_axi_wstrb <= 4'hF;
    rd(12'h190, 32'h3F, 2'h0);
    powerOk <= 3'h1;
    wr(12'h184, 8'h41);
    rd(12'h184, 32'h40, 2'h0);
    rd(12'h154, 32'hFF, 2'h0);
    cmp({ldoEnable, dischargeOn}, 32'h2A);
    firstPowerOk <= 1'h1;
    wr(12'h144, 8'hFE);
    rd(12'h144, 32'h01, 2'h0);
    rd(12'h3FC, 32'h0, 2'h2);
    wr(12'h194, 8'hFD);
    regFault <= 3'h4;
    wr(12'h208, 8'h04);
    rd(12'h200, 32'h0, 2'h0);
    wr(12'h194, 8'hFF);
    rd(12'h200, 32'h4, 2'h0);
    cmp(irq, 32'h1);
    regFault <= 3'h0;
    wr(12'h208, 8'h00);
    cmp(irq, 32'h0);
    wr(12'h204, 8'h04);
    wr(12'h208, 8'h04);
    rd(12'h200, 32'h0, 2'h0);
    cmp(irq, 32'h0);
    wr(12'h200, 8'hFF);
    rd(12'h200, 32'h0, 2'h0);
    rd(12'h204, 32'h0, 2'h0);
    wr(12'h154, 8'h34);
    cmp({ldoEnable[0], dischargeOn[0]}, 32'h0);
    cmp({lowQuiescentMode[0], turnOnDelay[2:0]}, 32'hD);
    summarize();
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end
endmodule // tb
